// File: rtl/fault_irq_pkg.sv
package fault_irq_pkg;

   // Register port address width and data width
   localparam int unsigned REG_AW       = 6;
   localparam int unsigned REG_DW       = 8;

   // Second-level register groups
   localparam int unsigned NGRP         = 10;
   localparam int unsigned G_STAT1      = 0;
   localparam int unsigned G_THERM      = 1;
   localparam int unsigned G_MODE       = 2;
   localparam int unsigned G_SWILIM     = 3;
   localparam int unsigned G_LDOILIM    = 4;
   localparam int unsigned G_SWUV       = 5;
   localparam int unsigned G_LDOUV      = 6;
   localparam int unsigned G_SWOV       = 7;
   localparam int unsigned G_LDOOV      = 8;
   localparam int unsigned G_BTN        = 9;

   // Each group holds latch, mask, sense at index 3*g + offset
   localparam int unsigned GRP_STRIDE   = 3;
   localparam int unsigned OFS_LATCH    = 0;
   localparam int unsigned OFS_MASK     = 1;
   localparam int unsigned OFS_SENSE    = 2;

   // Other register indices
   localparam logic [5:0]  A_SUMMARY    = 6'h1e;
   localparam logic [5:0]  A_BYP_CURRENT_LIMIT   = 6'h1f;
   localparam logic [5:0]  A_BYP_UV     = 6'h20;
   localparam logic [5:0]  A_BYP_OV     = 6'h21;
   localparam logic [5:0]  A_FAULT_CNT  = 6'h22;

   // Summary register bit positions
   localparam int unsigned S_STAT1      = 0;
   localparam int unsigned S_STAT2      = 1;
   localparam int unsigned S_MODE       = 2;
   localparam int unsigned S_CURRENT_LIMIT       = 3;
   localparam int unsigned S_UV         = 4;
   localparam int unsigned S_OV         = 5;
   localparam int unsigned S_BTN        = 6;
   localparam int unsigned S_EWARN      = 7;

   // Reset values
   localparam logic [7:0]  MASK_RST     = 8'h00;
   localparam logic [7:0]  ZERO8        = 8'h00;
   localparam logic [3:0]  CNT_RST      = 4'h0;
   localparam logic [3:0]  CNT_ONE      = 4'h1;

   // Power-up check window
   localparam int unsigned CLK_KHZ      = 20000;
   localparam int unsigned PG_WAIT_US   = 2000;
   localparam int unsigned PG_WAIT_CYC_DEF = (PG_WAIT_US * CLK_KHZ) / 1000;

   // Register port request
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [REG_AW-1:0] addr;
      logic [REG_DW-1:0] wdata;
   } reg_req_t;

   // Per-regulator vectors, order {ldo3,ldo2,ldo1,sw7,sw6,sw5,sw2,sw1}
   typedef struct packed {
      logic [7:0] current_limit;
      logic [7:0] uv;
      logic [7:0] ov;
   } reg_fault_t;

   // Power-up check states
   typedef enum logic [1:0] {
      PU_SEQ,
      PU_HOLD,
      PU_RUN,
      PU_ABORT
   } pu_state_t;

endpackage

// File: rtl/fault_bypass_powerup_check_irq.sv
`timescale 1ns/100ps
module fault_bypass_powerup_check_irq
   import fault_irq_pkg::*;
#(
   parameter int unsigned PG_WAIT_CYC = PG_WAIT_CYC_DEF
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset_n,
   // Register port from the serial interface
   input  wire reg_req_t           reg_req,
   output logic [REG_DW-1:0]       reg_rdata,
   // One-time-programmable configuration
   input  wire reg_fault_t         otp_bypass,
   input  wire logic               powerup_output_verify_cfg,
   // Regulator status from the analog side and sequencer
   input  wire reg_fault_t         fault_raw,
   input  wire logic [7:0]         internal_power_good,
   input  wire logic [7:0]         reg_enabled,
   input  wire logic [7:0]         blank_done,
   input  wire logic               reset_slot_due,
   input  wire logic [3:0]         fault_max_cnt,
   // Other interrupt sources: event pulses and live levels
   input  wire logic [7:0]         stat1_event,
   input  wire logic [7:0]         stat1_level,
   input  wire logic [7:0]         therm_event,
   input  wire logic [7:0]         therm_level,
   input  wire logic [7:0]         mode_event,
   input  wire logic [7:0]         button_event,
   input  wire logic [7:0]         button_level,
   input  wire logic               early_warning_event,
   // Fault protection outputs
   output logic [3:0]              fault_count,
   output logic                    fault_timer_start,
   output logic [7:0]              reg_fault_disable,
   output logic [7:0]              regulator_off,
   output logic                    seq_pause,
   output logic                    powerup_abort,
   // Open-drain pins: data and enable
   output logic                    processor_reset_out_n,
   output logic                    processor_reset_oe,
   output logic                    power_good_pin,
   output logic                    power_good_oe,
   output logic                    interrupt_out_n,
   output logic                    interrupt_oe
);

   localparam int unsigned WCW = $clog2(PG_WAIT_CYC + 1);
   localparam logic [WCW-1:0] WAIT_LAST = WCW'(PG_WAIT_CYC - 1);
   localparam logic [WCW-1:0] WAIT_ZERO = '0;
   localparam logic [WCW-1:0] WAIT_ONE  = WCW'(1);

   // Map a regulator vector onto the switching register bit layout
   function automatic logic [7:0] sw_bits(input logic [7:0] v);
      sw_bits = {1'b0, v[4:2], 2'b00, v[1:0]};
   endfunction

   // Map a regulator vector onto the linear register bit layout
   function automatic logic [7:0] ldo_bits(input logic [7:0] v);
      ldo_bits = {5'b00000, v[7:5]};
   endfunction

   // Write-one-to-clear with set priority
   function automatic logic [7:0] w1c(input logic [7:0] cur,
                                      input logic [7:0] set,
                                      input logic       hit,
                                      input logic [7:0] data);
      w1c = (cur & ~(hit ? data : ZERO8)) | set;
   endfunction

   // Register index of a group register
   function automatic logic [5:0] grp_addr(input int unsigned g,
                                           input int unsigned ofs);
      grp_addr = 6'(g * GRP_STRIDE + ofs);
   endfunction

   // Bypass state, one bit per regulator per fault type
   reg_fault_t       bypass_q;                 // Live bypass controls
   reg_fault_t       qual_q;                   // Monitored faults, delayed
   // Interrupt state
   logic [7:0]       lat_q [NGRP];             // Second-level latches
   logic [7:0]       msk_q [NGRP];             // Second-level masks
   logic             ewarn_q;                  // Early warning latch
   // Power-up check
   pu_state_t        pu_q;                     // Check state
   pu_state_t        pu_d;
   logic [WCW-1:0]   wait_q;                   // Hold window counter
   logic [WCW-1:0]   wait_d;
   // Registered outputs
   logic [REG_DW-1:0] rdata_q;
   logic [3:0]       cnt_q;
   logic             tstart_q;
   logic [7:0]       rdis_q;
   logic [7:0]       off_q;
   logic             pause_q;
   logic             abort_q;
   logic             rst_out_q;
   logic             pg_low_q;
   logic             irq_q;
   logic             rst_oe_q;                 // Reset pin drive enable
   logic             pg_pin_q;                 // Power good pin level
   logic             irq_n_q;                  // Interrupt pin level

   // Regulators whose OV/UV/CURRENT_LIMIT are watched: only after reset release
   wire logic        released   = (pu_q == PU_RUN);
   wire logic [7:0]  monitor    = {8{released}} & reg_enabled
                                  & blank_done;
   wire reg_fault_t  qual       = '{current_limit: fault_raw.current_limit & monitor,
                                    uv:   fault_raw.uv & monitor,
                                    ov:   fault_raw.ov & monitor};
   // New fault events: rising edge of a monitored condition
   wire reg_fault_t  fevt       = qual & ~qual_q;
   // Events that feed the protection chain exclude bypassed faults
   wire reg_fault_t  prot_evt   = fevt & ~bypass_q;
   wire reg_fault_t  prot_lvl   = qual & ~bypass_q;
   wire logic        any_prot   = |prot_evt;
   // Power good held low before release or on a live protected undervoltage or overvoltage (current limit never drops it);
   // bypassed overvoltage and undervoltage never take part
   wire logic        pg_drop    = !released
                                  || (|(prot_lvl.uv | prot_lvl.ov));

   // All regulators enabled so far in regulation
   wire logic        all_good   = &(internal_power_good | ~reg_enabled);

   // Register decode
   wire logic        wr         = reg_req.wr;
   wire logic [5:0]  addr       = reg_req.addr;
   wire logic [7:0]  wdata      = reg_req.wdata;
   wire logic        wr_sum     = wr && (addr == A_SUMMARY);
   wire logic        wr_cnt     = wr && (addr == A_FAULT_CNT);

   // Event set vectors per group; bypass never gates these
   logic [7:0]       evt  [NGRP];
   logic [7:0]       sns  [NGRP];
   assign evt[G_STAT1]   = stat1_event;
   assign evt[G_THERM]   = therm_event;
   assign evt[G_MODE]    = mode_event;
   assign evt[G_SWILIM]  = sw_bits(fevt.current_limit);
   assign evt[G_LDOILIM] = ldo_bits(fevt.current_limit);
   assign evt[G_SWUV]    = sw_bits(fevt.uv);
   assign evt[G_LDOUV]   = ldo_bits(fevt.uv);
   assign evt[G_SWOV]    = sw_bits(fevt.ov);
   assign evt[G_LDOOV]   = ldo_bits(fevt.ov);
   assign evt[G_BTN]     = button_event;

   // Live sense values, not latched
   assign sns[G_STAT1]   = stat1_level;
   assign sns[G_THERM]   = therm_level;
   assign sns[G_MODE]    = ZERO8;
   assign sns[G_SWILIM]  = sw_bits(fault_raw.current_limit);
   assign sns[G_LDOILIM] = ldo_bits(fault_raw.current_limit);
   assign sns[G_SWUV]    = sw_bits(fault_raw.uv);
   assign sns[G_LDOUV]   = ldo_bits(fault_raw.uv);
   assign sns[G_SWOV]    = sw_bits(fault_raw.ov);
   assign sns[G_LDOOV]   = ldo_bits(fault_raw.ov);
   assign sns[G_BTN]     = button_level;

   // Unmasked latch presence per group
   logic [NGRP-1:0]  grp_act;
   genvar gi;
   generate
      for (gi = 0; gi < NGRP; gi++) begin : g_act
         assign grp_act[gi] = |(lat_q[gi] & ~msk_q[gi]);
      end
   endgenerate

   // Summary is derived, so it clears with its latches
   wire logic [7:0]  summary = {
      ewarn_q,
      grp_act[G_BTN],
      grp_act[G_SWOV]   | grp_act[G_LDOOV],
      grp_act[G_SWUV]   | grp_act[G_LDOUV],
      grp_act[G_SWILIM] | grp_act[G_LDOILIM],
      grp_act[G_MODE],
      grp_act[G_THERM],
      grp_act[G_STAT1]};
   // Any summary bit keeps the interrupt pin asserted
   wire logic        irq_any = |summary;

   // Read multiplexer, combinational
   logic [7:0]       rd_mux;
   always_comb begin
      rd_mux = ZERO8;
      for (int unsigned g = 0; g < NGRP; g++) begin
         if (addr == grp_addr(g, OFS_LATCH)) begin
            rd_mux = lat_q[g];
         end
         if (addr == grp_addr(g, OFS_MASK)) begin
            rd_mux = msk_q[g];
         end
         if (addr == grp_addr(g, OFS_SENSE)) begin
            rd_mux = sns[g];
         end
      end
      unique case (addr)
         A_SUMMARY:   rd_mux = summary;
         A_BYP_CURRENT_LIMIT:  rd_mux = bypass_q.current_limit;
         A_BYP_UV:    rd_mux = bypass_q.uv;
         A_BYP_OV:    rd_mux = bypass_q.ov;
         A_FAULT_CNT: rd_mux = {4'h0, cnt_q};
         default:     ;
      endcase
   end

   // Power-up check next state
   always_comb begin
      pu_d   = pu_q;
      wait_d = wait_q;
      unique case (pu_q)
         PU_SEQ: begin
            if (reset_slot_due) begin
               if (!powerup_output_verify_cfg || all_good) begin
                  pu_d = PU_RUN;
               end else begin
                  pu_d   = PU_HOLD;
                  wait_d = WAIT_ZERO;
               end
            end
         end
         PU_HOLD: begin
            if (all_good) begin
               pu_d = PU_RUN;
            end else if (wait_q == WAIT_LAST) begin
               pu_d = PU_ABORT;
            end else begin
               wait_d = wait_q + WAIT_ONE;
            end
         end
         // Once released, later faults never pause the sequence
         PU_RUN:   pu_d = PU_RUN;
         PU_ABORT: pu_d = PU_ABORT;
      endcase
   end

   // Bypass controls; OTP defaults taken while reset is held
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bypass_q <= otp_bypass;
      end else if (wr) begin
         if (addr == A_BYP_CURRENT_LIMIT) begin
            bypass_q.current_limit <= wdata;
         end
         if (addr == A_BYP_UV) begin
            bypass_q.uv <= wdata;
         end
         if (addr == A_BYP_OV) begin
            bypass_q.ov <= wdata;
         end
      end
   end

   // Interrupt latches and masks
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int unsigned g = 0; g < NGRP; g++) begin
            lat_q[g] <= ZERO8;
            msk_q[g] <= MASK_RST;
         end
         ewarn_q <= 1'b0;
      end else begin
         for (int unsigned g = 0; g < NGRP; g++) begin
            lat_q[g] <= w1c(lat_q[g], evt[g],
                            wr && (addr == grp_addr(g, OFS_LATCH)),
                            wdata);
            if (wr && (addr == grp_addr(g, OFS_MASK))) begin
               msk_q[g] <= wdata;
            end
         end
         // Early warning has no mask; set beats clear
         ewarn_q <= early_warning_event
                    | (ewarn_q & ~(wr_sum & wdata[S_EWARN]));
      end
   end

   // Fault counter and protection actions
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         qual_q   <= '0;
         cnt_q    <= CNT_RST;
         tstart_q <= 1'b0;
         rdis_q   <= ZERO8;
      end else begin
         qual_q   <= qual;
         tstart_q <= any_prot;
         rdis_q   <= prot_lvl.current_limit | prot_lvl.uv | prot_lvl.ov;
         // A new event outranks a host clear unless the count is at fault_max_cnt, where the clear wins
         if (any_prot && (cnt_q != fault_max_cnt)) begin
            cnt_q <= cnt_q + CNT_ONE;
         end else if (wr_cnt) begin
            cnt_q <= CNT_RST;
         end
      end
   end

   // Power-up check state and sequencer handshake
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pu_q      <= PU_SEQ;
         wait_q    <= WAIT_ZERO;
         rst_out_q <= 1'b0;
         rst_oe_q  <= 1'b1;
         pause_q   <= 1'b0;
         abort_q   <= 1'b0;
         off_q     <= ZERO8;
      end else begin
         pu_q      <= pu_d;
         wait_q    <= wait_d;
         rst_out_q <= (pu_d == PU_RUN);
         rst_oe_q  <= (pu_d != PU_RUN);
         pause_q   <= (pu_d == PU_HOLD);
         abort_q   <= (pu_d == PU_ABORT);
         if ((pu_q == PU_HOLD) && (pu_d == PU_ABORT)) begin
            off_q <= reg_enabled;
         end
      end
   end

   // Pins and read data
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_q  <= ZERO8;
         pg_low_q <= 1'b1;
         pg_pin_q <= 1'b0;
         irq_q    <= 1'b0;
         irq_n_q  <= 1'b1;
      end else begin
         if (reg_req.rd) begin
            rdata_q <= rd_mux;
         end
         // Level and enable as twin flops, so no pin sits behind a gate
         pg_low_q <= pg_drop;
         pg_pin_q <= !pg_drop;
         irq_q    <= irq_any;
         irq_n_q  <= !irq_any;
      end
   end

   // Output drive; open-drain pins only ever drive low
   assign reg_rdata             = rdata_q;
   assign fault_count           = cnt_q;
   assign fault_timer_start     = tstart_q;
   assign reg_fault_disable     = rdis_q;
   assign regulator_off         = off_q;
   assign seq_pause             = pause_q;
   assign powerup_abort         = abort_q;
   assign processor_reset_out_n = rst_out_q;
   assign processor_reset_oe    = rst_oe_q;
   assign power_good_pin        = pg_pin_q;
   assign power_good_oe         = pg_low_q;
   assign interrupt_out_n       = irq_n_q;
   assign interrupt_oe          = irq_q;

endmodule

// File: testbench/fault_irq_monitor.sv
`timescale 1ns/100ps
module fault_irq_monitor (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Sequencer and supply status
   input  wire logic       powerup_output_verify_cfg,
   input  wire logic       reset_slot_due,
   input  wire logic [7:0] internal_power_good,
   input  wire logic [7:0] reg_enabled,
   input  wire logic       early_warning_event,
   // Protection outputs
   input  wire logic [3:0] fault_count,
   input  wire logic       fault_timer_start,
   input  wire logic [7:0] regulator_off,
   input  wire logic       seq_pause,
   input  wire logic       powerup_abort,
   // Open-drain pins
   input  wire logic       processor_reset_out_n,
   input  wire logic       processor_reset_oe,
   input  wire logic       power_good_pin,
   input  wire logic       power_good_oe,
   input  wire logic       interrupt_out_n,
   input  wire logic       interrupt_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Every enabled regulator in regulation; idle ones do not count
   wire all_good = &(internal_power_good | ~reg_enabled);

   AST_EWARN_PIN: assert property (
      early_warning_event |-> ##2 !interrupt_out_n)
      else $error("early warning did not pull the interrupt pin");
   AST_PIN_PAIR: assert property (
      interrupt_oe == !interrupt_out_n)
      else $error("interrupt pin level and enable disagree");
   AST_RST_PAIR: assert property (
      processor_reset_oe == !processor_reset_out_n)
      else $error("reset pin level and enable disagree");
   AST_PG_PAIR: assert property (
      power_good_oe == !power_good_pin)
      else $error("power good pin level and enable disagree");
   AST_PAUSE_HOLD: assert property (
      seq_pause |-> processor_reset_oe && !processor_reset_out_n)
      else $error("processor reset let go while paused");
   AST_AFTER_REL: assert property (
      processor_reset_out_n |-> !seq_pause && !powerup_abort)
      else $error("sequence stopped after reset release");
   AST_ABORT_FROM_HOLD: assert property (
      $rose(powerup_abort) |-> $past(seq_pause) && !seq_pause)
      else $error("abort without a preceding hold");
   AST_OFF_STICKY: assert property (
      powerup_abort && $past(powerup_abort) |-> $stable(regulator_off))
      else $error("regulators switched back after abort");
   AST_NOCHECK_REL: assert property (
      !powerup_output_verify_cfg && reset_slot_due && !seq_pause
      && !powerup_abort && !processor_reset_out_n
      |=> processor_reset_out_n)
      else $error("reset not released with check off");
   AST_GOOD_REL: assert property (
      $rose(processor_reset_out_n) && $past(powerup_output_verify_cfg)
      |-> $past(all_good))
      else $error("reset released without power good");
   AST_COUNT_TIMER: assert property (
      $changed(fault_count) && fault_count != 4'h0 |-> fault_timer_start)
      else $error("counter moved without a timer start");
   AST_PG_BEFORE_REL: assert property (
      !processor_reset_out_n |-> power_good_oe && !power_good_pin)
      else $error("power good pin released before reset release");

   // Main scenarios reached
   cover property ($rose(powerup_abort));
   cover property ($rose(processor_reset_out_n));
   cover property ($rose(interrupt_oe));
endmodule

bind fault_bypass_powerup_check_irq fault_irq_monitor fault_irq_monitor_inst (
   .clk, .reset_n, .powerup_output_verify_cfg, .reset_slot_due,
   .internal_power_good, .reg_enabled, .early_warning_event, .fault_count,
   .fault_timer_start, .regulator_off, .seq_pause, .powerup_abort,
   .processor_reset_out_n, .processor_reset_oe, .power_good_pin,
   .power_good_oe, .interrupt_out_n, .interrupt_oe);

// File: testbench/host_port.sv
`timescale 1ns/100ps
module host_port
   import fault_irq_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Register port towards the device
   output reg_req_t        reg_req,
   input  wire logic [7:0] reg_rdata
);
   // Idle request: no strobe
   initial reg_req = '0;
   // Write strobe lives for exactly one sampling edge
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_req <= {1'b1, 1'b0, a, d};
      @(posedge clk);
      reg_req <= '0;
   endtask
   // Read answer is registered, so take it half a cycle later
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_req <= {1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      reg_req <= '0;
      @(negedge clk);
      d = reg_rdata;
   endtask
endmodule

// File: testbench/tb_fault_bypass_powerup_check_irq.sv
`timescale 1ns/100ps
module tb_fault_bypass_powerup_check_irq;
   import fault_irq_pkg::*;
   localparam int PGW = 20;    // Short hold window for simulation
   logic clk = 0, reset_n = 0, cfg = 1, due = 0, ewarn = 0;
   logic [7:0] pg = 0, en = 0, blank = 8'hff, s1e = 0, s1l = 8'h05;
   logic [7:0] the = 0, thl = 8'h3c, mde = 0, bte = 0, btl = 0;
   logic [3:0] maxc = 4'hf;    // Never reached here
   reg_fault_t byp = '{8'h01, 8'h02, 8'h00};
   reg_fault_t raw = '0;
   reg_req_t req;
   logic [7:0] rdat, dis, off;
   logic [3:0] cnt;
   logic tmr, pau, abt, rsn, rsoe, pgp, pgoe, inn, inoe;
   int err_count = 0, check_count = 0;

   always #25 clk = ~clk;

   host_port host_port_inst (.clk(clk), .reg_req(req), .reg_rdata(rdat));
   fault_bypass_powerup_check_irq #(.PG_WAIT_CYC(PGW))
   fault_bypass_powerup_check_irq_inst (
      .clk(clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(rdat),
      .otp_bypass(byp), .powerup_output_verify_cfg(cfg),
      .fault_raw(raw), .internal_power_good(pg), .reg_enabled(en),
      .blank_done(blank), .reset_slot_due(due), .fault_max_cnt(maxc),
      .stat1_event(s1e), .stat1_level(s1l), .therm_event(the),
      .therm_level(thl), .mode_event(mde), .button_event(bte),
      .button_level(btl), .early_warning_event(ewarn),
      .fault_count(cnt), .fault_timer_start(tmr),
      .reg_fault_disable(dis), .regulator_off(off), .seq_pause(pau),
      .powerup_abort(abt), .processor_reset_out_n(rsn),
      .processor_reset_oe(rsoe), .power_good_pin(pgp),
      .power_good_oe(pgoe), .interrupt_out_n(inn), .interrupt_oe(inoe));

   // Register index of a group member
   function automatic logic [5:0] ad(int g, int o);
      return 6'(g * GRP_STRIDE + o);
   endfunction
   // Compare seen against expected, four-state exact
   task chk(string n, logic [7:0] got, logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", n, exp, got);
      end
   endtask
   task rchk(string n, logic [5:0] a, logic [7:0] e);
      logic [7:0] d;
      host_port_inst.rd(a, d);
      chk(n, d, e);
   endtask
   // Let n edges pass, then sample settled outputs
   task cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task rst_cycle;
      @(posedge clk) begin reset_n <= 0; due <= 0; end
      repeat (10) @(posedge clk);
      reset_n <= 1;
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Watchdog sized well beyond the whole sequence
   initial begin
      #(3000 * 50);
      err_count++;
      summarize();
   end

   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1;
      rchk("byp_current_limit", A_BYP_CURRENT_LIMIT, 8'h01);
      rchk("byp_uv", A_BYP_UV, 8'h02);
      rchk("byp_ov", A_BYP_OV, 8'h00);
      rchk("mask1", ad(G_STAT1, OFS_MASK), MASK_RST);
      rchk("unmapped", 6'h3f, 8'h00);
      rchk("sense1", ad(G_STAT1, OFS_SENSE), 8'h05);
      rchk("thermal_watchdog_sense", ad(G_THERM, OFS_SENSE), 8'h3c);
      $display("test reset_values done");
      // Hold at the reset slot, then recover inside the window
      @(posedge clk) begin en <= 8'h03; pg <= 8'h01; due <= 1; end
      cyc(5);
      chk("pause", pau, 1);
      chk("reset_pin", rsn, 0);
      @(posedge clk) pg <= 8'h03;
      cyc(3);
      chk("reset_pin", rsn, 1);
      chk("reset_oe", rsoe, 0);
      $display("test hold_recover done");
      // Bypassed undervoltage first, then a live overvoltage
      @(posedge clk) raw.uv <= 8'h02;
      cyc(1);
      chk("timer", tmr, 0);
      cyc(3);
      chk("count", cnt, 0);
      chk("disable", dis, 0);
      chk("pg_oe", pgoe, 0);
      chk("pg_pin", pgp, 1);
      chk("int_oe", inoe, 1);
      chk("int_pin", inn, 0);
      @(posedge clk) raw.ov <= 8'h01;
      cyc(1);
      chk("timer", tmr, 1);
      cyc(3);
      chk("count", cnt, 1);
      chk("disable", dis, 8'h01);
      chk("pg_oe", pgoe, 1);
      chk("pg_pin", pgp, 0);
      rchk("summary", A_SUMMARY, 8'h30);
      rchk("sw_uv", ad(G_SWUV, OFS_LATCH), 8'h02);
      rchk("uv_sense", ad(G_SWUV, OFS_SENSE), 8'h02);
      host_port_inst.wr(ad(G_SWUV, OFS_LATCH), 8'h00);
      rchk("sw_uv", ad(G_SWUV, OFS_LATCH), 8'h02);
      host_port_inst.wr(ad(G_SWUV, OFS_LATCH), 8'h02);
      rchk("summary", A_SUMMARY, 8'h20);
      chk("int_oe", inoe, 1);
      host_port_inst.wr(ad(G_SWOV, OFS_MASK), 8'h01);
      cyc(3);
      chk("int_oe", inoe, 0);
      chk("int_pin", inn, 1);
      rchk("summary", A_SUMMARY, 8'h00);
      rchk("sw_ov", ad(G_SWOV, OFS_LATCH), 8'h01);
      @(posedge clk) raw <= '0;
      rchk("count", A_FAULT_CNT, 8'h01);
      host_port_inst.wr(A_FAULT_CNT, 8'h00);
      rchk("count", A_FAULT_CNT, 8'h00);
      $display("test fault_bypass done");
      // Masked status event beside an unmasked button event
      host_port_inst.wr(ad(G_STAT1, OFS_MASK), 8'hff);
      @(posedge clk) begin s1e <= 8'h01; bte <= 8'h80; end
      @(posedge clk) begin s1e <= 8'h00; bte <= 8'h00; end
      rchk("stat1", ad(G_STAT1, OFS_LATCH), 8'h01);
      rchk("summary", A_SUMMARY, 8'h40);
      host_port_inst.wr(ad(G_BTN, OFS_LATCH), 8'h80);
      cyc(3);
      chk("int_oe", inoe, 0);
      host_port_inst.wr(ad(G_STAT1, OFS_MASK), 8'h00);
      cyc(3);
      chk("int_oe", inoe, 1);
      host_port_inst.wr(ad(G_STAT1, OFS_LATCH), 8'h01);
      cyc(3);
      chk("int_oe", inoe, 0);
      @(posedge clk) ewarn <= 1;
      @(posedge clk) ewarn <= 0;
      rchk("summary", A_SUMMARY, 8'h80);
      host_port_inst.wr(A_SUMMARY, 8'h80);
      cyc(3);
      chk("int_oe", inoe, 0);
      $display("test interrupts done");
      // Supply stays out of regulation past the hold window
      @(posedge clk) begin en <= 8'h07; pg <= 8'h01; end
      rst_cycle();
      @(posedge clk) due <= 1;
      cyc(PGW);
      chk("abort", abt, 0);
      chk("pause", pau, 1);
      cyc(1);
      chk("abort", abt, 1);
      chk("reset_oe", rsoe, 1);
      chk("reg_off", off, 8'h07);
      chk("reset_pin", rsn, 0);
      $display("test abort done");
      // Check disabled: release without power good
      @(posedge clk) begin cfg <= 0; pg <= 8'h00; end
      rst_cycle();
      @(posedge clk) raw.uv <= 8'h01;
      rchk("sw_uv", ad(G_SWUV, OFS_LATCH), 8'h00);
      @(posedge clk) due <= 1;
      cyc(3);
      chk("reset_pin", rsn, 1);
      cyc(3);
      rchk("sw_uv", ad(G_SWUV, OFS_LATCH), 8'h01);
      $display("test no_check done");
      summarize();
   end
endmodule
